/* File: rtl/drsel_event_select.sv */
// Decode and rename stall event selector with its counter
//
// Function
// - D1/01 with invert and threshold one counts decoder stall cycles.
// - D1/02 adds uops supplied by the microcode sequencer each cycle.
// - Sequencer supplies uops for instructions over four uops or assists.
// - D1/04 counts decoded stack pointer instructions.
// - Stack instructions emit no adjust uop; they update the fold offset.
// - D1/08 counts syncs; a sync adds fold offset into stack pointer.
// - D2/01 counts flag stall cycles, partial flag stalls included.
// - Partial flag stall: partial flag writer, then read of unwritten flags.
// - D2/02 counts extra latency cycles from partially written registers.
// - D2/04 counts cycles a reorder buffer read port stall blocks entry.
// - Blocked micro-ops retry next cycle; recurring stall counted again.
// - D2/08 counts microcode scoreboard serialization stall cycles.
// - D2/0F counts any read port, partial, flag or status word stall.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "drsel_regs.svh"

module drsel_event_select
   import drsel_pkg::*;
(
   input  wire logic            ref_clk_i,
   input  wire logic            nrst_i,
   input  wire logic [3:0]      addr_i,
   input  wire logic [31:0]     wdata_i,
   input  wire logic            wr_i,
   input  wire logic            rd_i,
   output logic      [31:0]     rdata_o,
   input  wire logic            dec_valid_i,
   input  wire logic [3:0]      dec_len_i,
   input  wire logic            assist_i,
   input  wire logic [2:0]      decoder_uops_i,
   input  wire logic [2:0]      seq_uops_i,
   input  wire logic            seq_done_i,
   input  wire logic            stack_op_i,
   input  wire logic [7:0]      stack_delta_i,
   input  wire logic            stack_sync_i,
   input  wire logic            flag_wr_valid_i,
   input  wire logic [5:0]      flag_wr_mask_i,
   input  wire logic            flag_rd_valid_i,
   input  wire logic [5:0]      flag_rd_mask_i,
   input  wire logic            flag_stall_other_i,
   input  wire logic            partial_reg_stall_i,
   input  wire logic            read_port_stall_i,
   input  wire logic            scoreboard_stall_i,
   input  wire logic            fpsw_stall_i,
   output logic                 seq_select_o,
   output logic                 partial_flag_stall_o,
   output logic                 count_step_o
);

   ////////////////////////////////////////////////////////////////////////
   // State

   drsel_word_type  ctrl_r;
   drsel_word_type  count_r;
   drsel_word_type  count_nxt;
   drsel_word_type  stack_pointer_r;
   drsel_word_type  stack_fold_offset_r;
   drsel_word_type  fold_nxt;
   drsel_word_type  sp_nxt;
   drsel_word_type  rdata_r;
   drsel_word_type  rdata_nxt;
   drsel_flags_type last_wr_mask_r;
   logic            last_partial_r;
   logic            seq_active_r;
   logic            count_step_r;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Widen a small per-cycle count to the four-bit step width
   function automatic drsel_cnt_type widen3(input logic [2:0] v);
      widen3 = {1'b0, v};
   endfunction

   // Threshold compare; zero threshold passes the raw count through
   function automatic drsel_cnt_type apply_cmp(input drsel_cnt_type c,
                                               input drsel_cnt_type th,
                                               input logic invert_compare);
      if (th == 4'h0) begin
         apply_cmp = c;
      end else if (invert_compare) begin
         apply_cmp = (c < th) ? 4'h1 : 4'h0;
      end else begin
         apply_cmp = (c >= th) ? 4'h1 : 4'h0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Control field decode

   wire drsel_code_type sel_code  = ctrl_r[`DRSEL_EVT_LSB +: 8];
   wire drsel_code_type sel_umask = ctrl_r[`DRSEL_UMASK_LSB +: 8];
   wire logic           sel_en    = ctrl_r[`DRSEL_EN_BIT];
   wire logic           sel_inv   = ctrl_r[`DRSEL_INV_BIT];
   wire drsel_cnt_type  sel_cmask = ctrl_r[`DRSEL_CMASK_LSB +: 4];
   wire logic           is_decode = (sel_code == `DRSEL_EVT_DECODE);
   wire logic           is_alloc  = (sel_code == `DRSEL_EVT_ALLOC);

   ////////////////////////////////////////////////////////////////////////
   // Microcode sequencer selection

   assign seq_select_o = dec_valid_i &&
      ((dec_len_i > `DRSEL_SEQ_MAX_UOPS) || assist_i);
   wire logic seq_busy = seq_select_o || seq_active_r;
   // Sequencer uops only counted while it owns the decode slot
   wire logic [2:0] seq_uops_cnt = seq_busy ? seq_uops_i : 3'h0;

   ////////////////////////////////////////////////////////////////////////
   // Partial flag stall detection

   assign partial_flag_stall_o = flag_rd_valid_i && last_partial_r &&
                  ((flag_rd_mask_i & ~last_wr_mask_r) != 6'h00);

   ////////////////////////////////////////////////////////////////////////
   // Sub-event selection

   wire logic flag_stall = partial_flag_stall_o || flag_stall_other_i;
   wire logic [4:0] alloc_src = {fpsw_stall_i, scoreboard_stall_i,
                                 read_port_stall_i, partial_reg_stall_i,
                                 flag_stall};
   // Any-stall covers read port, partial, flag and status word only
   wire logic alloc_any = alloc_src[0] || alloc_src[1] ||
                          alloc_src[2] || alloc_src[4];
   // Read port stall seen afresh every cycle it is raised again
   wire logic alloc_sel =
      |(alloc_src[3:0] & sel_umask[3:0]);
   wire logic alloc_hit = (sel_umask == `DRSEL_UM_ANY) ? alloc_any
                                                       : alloc_sel;

   // Decode sub-events add their counts when several are picked
   wire drsel_cnt_type dec_raw =
      (sel_umask[0] ? widen3(decoder_uops_i) : 4'h0) +
      (sel_umask[1] ? widen3(seq_uops_cnt) : 4'h0) +
      {3'h0, sel_umask[2] && stack_op_i} +
      {3'h0, sel_umask[3] && stack_sync_i};

   wire drsel_cnt_type raw_count = is_decode ? dec_raw :
                                   is_alloc  ? {3'h0, alloc_hit} : 4'h0;
   wire drsel_cnt_type step = sel_en ?
      apply_cmp(raw_count, sel_cmask, sel_inv) : 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // Stack pointer folding

   wire drsel_word_type delta_ext = {{24{stack_delta_i[7]}}, stack_delta_i};
   wire drsel_word_type fold_base = stack_sync_i ? 32'h0000_0000
                                                 : stack_fold_offset_r;
   assign fold_nxt = stack_op_i ? fold_base + delta_ext
                                : fold_base;
   assign sp_nxt = stack_sync_i ? stack_pointer_r + stack_fold_offset_r
                                : stack_pointer_r;

   ////////////////////////////////////////////////////////////////////////
   // Register port

   wire logic wr_ctrl  = wr_i && (addr_i == `DRSEL_ADDR_CTRL);
   wire logic wr_count = wr_i && (addr_i == `DRSEL_ADDR_COUNT);
   wire logic wr_sp    = wr_i && (addr_i == `DRSEL_ADDR_SP);

   // Software load of the counter wins over a same-cycle step
   assign count_nxt = wr_count ? wdata_i : count_r + {28'h0, step};

   assign rdata_nxt = !rd_i ? 32'h0000_0000 :
      (addr_i == `DRSEL_ADDR_CTRL)  ? ctrl_r :
      (addr_i == `DRSEL_ADDR_COUNT) ? count_r :
      (addr_i == `DRSEL_ADDR_SP)    ? stack_pointer_r :
      (addr_i == `DRSEL_ADDR_FOLD)  ? stack_fold_offset_r : 32'h0000_0000;

   assign rdata_o      = rdata_r;
   assign count_step_o = count_step_r;

   ////////////////////////////////////////////////////////////////////////
   // Flip-flops

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_r              <= `DRSEL_CTRL_RESET;
         count_r             <= `DRSEL_COUNT_RESET;
         stack_pointer_r     <= `DRSEL_SP_RESET;
         stack_fold_offset_r <= `DRSEL_FOLD_RESET;
         rdata_r             <= 32'h0000_0000;
         count_step_r        <= 1'b0;
      end else begin
         ctrl_r              <= wr_ctrl ? wdata_i : ctrl_r;
         count_r             <= count_nxt;
         stack_pointer_r     <= wr_sp ? wdata_i : sp_nxt;
         stack_fold_offset_r <= fold_nxt;
         rdata_r             <= rdata_nxt;
         count_step_r        <= (step != 4'h0) && !wr_count;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         last_wr_mask_r <= `DRSEL_FLAGS_ALL;
         last_partial_r <= 1'b0;
         seq_active_r   <= 1'b0;
      end else begin
         if (flag_wr_valid_i) begin
            last_wr_mask_r <= flag_wr_mask_i;
            last_partial_r <= (flag_wr_mask_i != `DRSEL_FLAGS_ALL) &&
                              (flag_wr_mask_i != 6'h00);
         end
         seq_active_r <= seq_select_o || (seq_active_r && !seq_done_i);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   a_decoder_stall_count: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (sel_en && is_decode && sel_umask == 8'h01 && sel_inv &&
       sel_cmask == 4'h1 && !wr_count)
      |=> count_r == $past(count_r) + ((($past(decoder_uops_i) == 3'h0))
                                       ? 32'h1 : 32'h0))
      else $error("decoder stall cycle not counted correctly");

   a_seq_uops_add: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (sel_en && is_decode && sel_umask == 8'h02 && sel_cmask == 4'h0 &&
       !wr_count && seq_busy)
      |=> count_r == $past(count_r) + {29'h0, $past(seq_uops_i)})
      else $error("sequencer uops not added to counter");

   a_seq_long_instr: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (dec_valid_i && dec_len_i > 4'h4) |-> seq_select_o ##1 seq_active_r)
      else $error("long instruction not sent to sequencer");

   a_stack_op_count: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (sel_en && is_decode && sel_umask == 8'h04 && sel_cmask == 4'h0 &&
       !wr_count)
      |=> count_r == $past(count_r) + {31'h0, $past(stack_op_i)})
      else $error("stack pointer instruction count wrong");

   a_fold_update: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (stack_op_i && !stack_sync_i) |=>
      stack_fold_offset_r == $past(stack_fold_offset_r) + $past(delta_ext))
      else $error("fold offset not updated by stack instruction");

   a_sync_adds_fold: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (stack_sync_i && !wr_sp) |=>
      stack_pointer_r == $past(stack_pointer_r) +
                         $past(stack_fold_offset_r))
      else $error("sync did not fold offset into stack pointer");

   a_partial_flag_detect: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (flag_wr_valid_i && flag_wr_mask_i == 6'h01) ##1
      (flag_rd_valid_i && !flag_wr_valid_i && flag_rd_mask_i == 6'h02)
      |-> partial_flag_stall_o)
      else $error("partial flag stall missed");

   a_partial_reg_count: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (sel_en && is_alloc && sel_umask == 8'h02 && sel_cmask == 4'h0 &&
       !wr_count)
      |=> count_r == $past(count_r) + {31'h0, $past(partial_reg_stall_i)})
      else $error("partial register stall cycles miscounted");

   a_read_port_recount: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (sel_en && is_alloc && sel_umask == 8'h04 && sel_cmask == 4'h0 &&
       !wr_count && read_port_stall_i)[*2]
      |=> count_r == $past(count_r, 2) + 32'h2)
      else $error("recurring read port stall not counted twice");

   a_scoreboard_count: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (sel_en && is_alloc && sel_umask == 8'h08 && sel_cmask == 4'h0 &&
       !wr_count)
      |=> count_r == $past(count_r) + {31'h0, $past(scoreboard_stall_i)})
      else $error("scoreboard stall cycles miscounted");

   a_any_alloc_stall: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (sel_en && is_alloc && sel_umask == 8'h0f && sel_cmask == 4'h0 &&
       !wr_count && fpsw_stall_i)
      |=> count_r == $past(count_r) + 32'h1 && count_step_o)
      else $error("status word stall missing from any-stall count");

   a_stall_or_combine: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (sel_en && is_alloc && sel_umask == 8'h03 && sel_cmask == 4'h0 &&
       !wr_count && flag_stall_other_i && partial_reg_stall_i)
      |=> count_r == $past(count_r) + 32'h1)
      else $error("combined stall sub-conditions not counted once");

   a_threshold_block: assert property (@(posedge ref_clk_i)
      disable iff (!nrst_i)
      (sel_cmask != 4'h0 && !sel_inv && raw_count < sel_cmask && !wr_count)
      |=> $stable(count_r) && !count_step_o)
      else $error("counter moved below threshold");

endmodule

`default_nettype wire

/* File: pkg/drsel_regs.svh */
// Register offsets, field positions, reset values and event codes
`ifndef DRSEL_REGS_SVH
`define DRSEL_REGS_SVH

`define DRSEL_ADDR_CTRL    4'h0
`define DRSEL_ADDR_COUNT   4'h4
`define DRSEL_ADDR_SP      4'h8
`define DRSEL_ADDR_FOLD    4'hc

`define DRSEL_EVT_LSB      0
`define DRSEL_UMASK_LSB    8
`define DRSEL_EN_BIT       16
`define DRSEL_INV_BIT      17
`define DRSEL_CMASK_LSB    24

`define DRSEL_CTRL_RESET   32'h0000_0000
`define DRSEL_COUNT_RESET  32'h0000_0000
`define DRSEL_SP_RESET     32'h0000_0000
`define DRSEL_FOLD_RESET   32'h0000_0000

`define DRSEL_EVT_DECODE   8'hd1
`define DRSEL_EVT_ALLOC    8'hd2
`define DRSEL_UM_ANY       8'h0f

`define DRSEL_SEQ_MAX_UOPS 4'h4
`define DRSEL_FLAGS_ALL    6'h3f

`endif

/* File: pkg/drsel_pkg.sv */
// Types shared by the decode and rename event selector
package drsel_pkg;
   typedef logic [31:0] drsel_word_type;
   typedef logic [7:0]  drsel_code_type;
   typedef logic [3:0]  drsel_cnt_type;
   typedef logic [5:0]  drsel_flags_type;
endpackage

/* File: testbench/drsel_pipe_model.sv */
// Far-side model: decode and rename pipeline conditions per cycle
`timescale 1ns/1ps
`default_nettype none
module drsel_pipe_model (
   input  wire logic [12:0] go_i,
   output logic             dec_valid_o,
   output logic [3:0]       dec_len_o,
   output logic             assist_o,
   output logic [2:0]       decoder_uops_o,
   output logic [2:0]       seq_uops_o,
   output logic             seq_done_o,
   output logic             stack_op_o,
   output logic [7:0]       stack_delta_o,
   output logic             stack_sync_o,
   output logic             flag_wr_valid_o,
   output logic [5:0]       flag_wr_mask_o,
   output logic             flag_rd_valid_o,
   output logic [5:0]       flag_rd_mask_o,
   output logic             flag_other_o,
   output logic             preg_stall_o,
   output logic             rport_stall_o,
   output logic             sboard_stall_o,
   output logic             fpsw_stall_o
);
   // Bit 12 is a four-uop case that must not count as sequencer work
   assign dec_valid_o     = go_i[7] | go_i[11] | go_i[12];
   assign dec_len_o       = go_i[7] ? 4'h5 : (go_i[12] ? 4'h4 : 4'h2);
   assign assist_o        = go_i[11];
   assign seq_uops_o      = go_i[7] ? 3'h3 :
                            (go_i[11] | go_i[12]) ? 3'h1 : 3'h0;
   assign seq_done_o      = ~(go_i[7] | go_i[11]);
   // Stack ops send no adjust uop; delta is junk when no op
   assign decoder_uops_o  = go_i[8] ? 3'h0 : 3'h2;
   assign stack_op_o      = go_i[0];
   assign stack_delta_o   = go_i[0] ? 8'h04 : 8'hfc;
   assign stack_sync_o    = go_i[1];
   assign rport_stall_o   = go_i[2];
   assign preg_stall_o    = go_i[3];
   assign sboard_stall_o  = go_i[4];
   assign fpsw_stall_o    = go_i[5];
   assign flag_other_o    = go_i[6];
   assign flag_wr_valid_o = go_i[9];
   assign flag_wr_mask_o  = 6'h01;
   assign flag_rd_valid_o = go_i[10];
   assign flag_rd_mask_o  = 6'h02;
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the decode and rename event selector
`timescale 1ns/1ps
`default_nettype none
`include "drsel_regs.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
   $display("BAD %s expected %h seen %h", nm, e, s); end end
module tb_top
   import drsel_pkg::*;
;
   // Entry: code, umask, invert, threshold, pattern, step per cycle
   localparam logic [43:0] TBL [18] = '{
      44'hd1_01_1_1_0100_1, 44'hd1_02_0_0_0080_3, 44'hd1_02_0_0_0800_1,
      44'hd1_02_0_0_1000_0, 44'hd1_04_0_0_0001_1, 44'hd1_08_0_0_0002_1,
      44'hd1_0c_0_0_0003_2, 44'hd1_02_0_3_0080_1, 44'hd1_02_0_4_0080_0,
      44'hd1_01_1_2_0100_1, 44'hd2_01_0_0_0040_1, 44'hd2_02_0_0_0008_1,
      44'hd2_04_0_0_0004_1, 44'hd2_08_0_0_0010_1, 44'hd2_0f_0_0_002c_1,
      44'hd2_0f_0_0_0010_0, 44'hd2_03_0_0_0048_1, 44'hd3_0f_0_0_00ff_0};
   logic           ref_clk_i = 1'b0;
   logic           nrst_i = 1'b0;
   logic [3:0]     addr_i = 4'h0;
   drsel_word_type wdata_i = 32'h0;
   logic           wr_i = 1'b0;
   logic           rd_i = 1'b0;
   logic           rd_seen = 1'b0;
   logic [12:0]    go = 13'h0;
   logic           flag_wr_seen = 1'b0;
   logic           seq_sel, pflag_stall, step_seen;
   drsel_word_type rdata_o, c, e, sp0, want, exp_q[$];
   int             fails = 0, n_compared = 0, seed = 87974, n;
   int             n_steps = 0, n0, s0;
   logic           dec_valid_i, assist_i, seq_done_i, stack_op_i;
   logic           stack_sync_i, flag_wr_valid_i, flag_rd_valid_i;
   logic           flag_stall_other_i, partial_reg_stall_i;
   logic           read_port_stall_i, scoreboard_stall_i, fpsw_stall_i;
   logic [3:0]     dec_len_i;
   logic [2:0]     decoder_uops_i, seq_uops_i;
   logic [7:0]     stack_delta_i;
   logic [5:0]     flag_wr_mask_i, flag_rd_mask_i;

   drsel_event_select uut (
      .ref_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .dec_valid_i, .dec_len_i, .assist_i, .decoder_uops_i, .seq_uops_i,
      .seq_done_i, .stack_op_i, .stack_delta_i, .stack_sync_i,
      .flag_wr_valid_i, .flag_wr_mask_i, .flag_rd_valid_i, .flag_rd_mask_i,
      .flag_stall_other_i, .partial_reg_stall_i, .read_port_stall_i,
      .scoreboard_stall_i, .fpsw_stall_i, .seq_select_o(seq_sel),
      .partial_flag_stall_o(pflag_stall), .count_step_o(step_seen));
   drsel_pipe_model pipe (
      .go_i(go), .dec_valid_o(dec_valid_i), .dec_len_o(dec_len_i),
      .assist_o(assist_i), .decoder_uops_o(decoder_uops_i),
      .seq_uops_o(seq_uops_i), .seq_done_o(seq_done_i),
      .stack_op_o(stack_op_i), .stack_delta_o(stack_delta_i),
      .stack_sync_o(stack_sync_i), .flag_wr_valid_o(flag_wr_valid_i),
      .flag_wr_mask_o(flag_wr_mask_i), .flag_rd_valid_o(flag_rd_valid_i),
      .flag_rd_mask_o(flag_rd_mask_i), .flag_other_o(flag_stall_other_i),
      .preg_stall_o(partial_reg_stall_i), .rport_stall_o(read_port_stall_i),
      .sboard_stall_o(scoreboard_stall_i), .fpsw_stall_o(fpsw_stall_i));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   // Read data stand only in the cycle after the strobe
   always @(posedge ref_clk_i) begin
      if (rd_seen) begin
         want = exp_q.pop_front();
         `CHK("rdata_o", want, rdata_o)
      end
      rd_seen <= rd_i;
      `CHK("seq_select_o", go[7] | go[11], seq_sel)
      `CHK("partial_flag_stall_o", go[10] & flag_wr_seen, pflag_stall)
      flag_wr_seen <= flag_wr_seen | go[9];
      if (step_seen === 1'b1)
         n_steps++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [3:0] a, input drsel_word_type d);
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input drsel_word_type x);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      exp_q.push_back(x);
      @(posedge ref_clk_i);
      rd_i   <= 1'b0;
   endtask
   task automatic run(input logic [12:0] p, input int k);
      @(posedge ref_clk_i);
      go <= p;
      repeat (k) @(posedge ref_clk_i);
      go <= 13'h0;
   endtask
   // Counter cleared while disabled so no stray cycles leak in
   task automatic arm(input drsel_word_type x);
      wr(`DRSEL_ADDR_CTRL, x);
      wr(`DRSEL_ADDR_COUNT, 32'h0);
      wr(`DRSEL_ADDR_CTRL, x | (32'h1 << `DRSEL_EN_BIT));
   endtask
   task automatic wrap_up;
      if (fails == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      fails++;
      wrap_up;
   end
   initial begin
      repeat (12) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      wr(4'h6, 32'hffff_ffff);
      for (int a = 0; a < 16; a += 2) begin
         rd(4'(a), 32'h0);
      end
      sp0 = drsel_word_type'($random(seed));
      wr(`DRSEL_ADDR_SP, sp0);
      n = 1 + ($random(seed) & 7);
      run(13'h0001, n);
      rd(`DRSEL_ADDR_FOLD, 32'h4 * n);
      wr(`DRSEL_ADDR_FOLD, ~sp0);
      rd(`DRSEL_ADDR_FOLD, 32'h4 * n);
      run(13'h0002, 2);
      rd(`DRSEL_ADDR_SP, sp0 + 32'h4 * n);
      rd(`DRSEL_ADDR_FOLD, 32'h0);
      c = 32'h0000_01d2;
      arm(c);
      // Reader follows the partial writer in the very next cycle
      @(posedge ref_clk_i);
      go <= 13'h0200;
      run(13'h0400, 2);
      wr(`DRSEL_ADDR_CTRL, c);
      rd(`DRSEL_ADDR_COUNT, 32'h2);
      foreach (TBL[i]) begin
         n = 1 + ($random(seed) & 7);
         n0 = n_steps;
         c = {4'h0, TBL[i][23:20], 6'h0, TBL[i][24], 1'b0, TBL[i][35:28],
              TBL[i][43:36]};
         e = drsel_word_type'(n * TBL[i][3:0]);
         arm(c);
         run(TBL[i][16:4], n);
         wr(`DRSEL_ADDR_CTRL, c);
         if (c[7:0] == 8'hd1)
            rd(`DRSEL_ADDR_COUNT, e);
         else
            rd(`DRSEL_ADDR_COUNT, e);
         s0 = (TBL[i][3:0] != 4'h0) ? n : 0;
         `CHK("count_step_o", s0, n_steps - n0)
      end
      repeat (4) @(posedge ref_clk_i);
      wrap_up;
   end
endmodule
`default_nettype wire
